//--- hdl/serial_link_pair.sv
// Serialiser and deserialiser ends of the 28-bit four-lane link.
//
// Overview of operation
// R1 - Capture whole word on each strobe rising edge.
// R2 - Send word on four lanes plus clock.
// R3 - Transmitter power-down floats all serial outputs.
// R4 - Receiver word strobed by output clock rising.
// R5 - Receiver power-down drives all parallel outputs low.
// R6 - Idle-high lanes with running clock yield ones.
// R7 - Stopped receive clock holds last word.
// R8 - Stopped receive clock holds strobe high.
// R9 - Seven bit slots per lane per clock.
// R10 - Controller asserts power-down while clock stopped.
// R11 - Outputs start after fixed lock time.
// R12 - Same fixed bit-to-slot map both ends.
// R13 - Receiver presents words only after lock.
`timescale 1ns/100ps
module serial_link_pair #(
    parameter int LOCK_CYCLES = serial_link_pkg::LOCK_CYCLES
) (
    input wire logic ref_clk, // System clock, 100 MHz.
    input wire logic rst_b, // Asynchronous reset, active low.
    input wire logic [27:0] parallel_tx_word, // Word to send.
    input wire logic tx_word_strobe_in, // Transmit word clock.
    input wire logic tx_power_down_n, // Transmitter power-down, low.
    output logic [3:0] serial_lane_out, // Serial data lanes.
    output logic [3:0] serial_lane_oe, // Lane drivers enabled.
    output logic forwarded_clock_out, // Forwarded clock lane.
    output logic forwarded_clock_oe, // Clock driver enabled.
    input wire logic [3:0] serial_lane_in, // Received serial lanes.
    input wire logic forwarded_clock_in, // Received clock lane.
    input wire logic rx_power_down_n, // Receiver power-down, low.
    output logic [27:0] parallel_rx_word, // Recovered word.
    output logic rx_word_strobe_out // Recovered word strobe.
);
    localparam int W = serial_link_pkg::WORD_BITS;
    localparam int L = serial_link_pkg::LANES;

    // Every pin input but ref_clk and rst_b passes two flip-flops before use.
    logic [W-1:0] tx_word_s1, tx_word_s2;
    logic tx_strobe_s1, tx_strobe_s2, tx_strobe_d;
    logic tx_pd_s1, tx_pd_s2;
    logic [L-1:0] rx_lane_s1, rx_lane_s2;
    logic rx_clk_s1, rx_clk_s2, rx_clk_d;
    logic rx_pd_s1, rx_pd_s2;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_word_s1 <= serial_link_pkg::WORD_RESET;
            tx_word_s2 <= serial_link_pkg::WORD_RESET;
            tx_strobe_s1 <= 1'b0;
            tx_strobe_s2 <= 1'b0;
            tx_strobe_d <= 1'b0;
            tx_pd_s1 <= 1'b0;
            tx_pd_s2 <= 1'b0;
            rx_lane_s1 <= 4'h0;
            rx_lane_s2 <= 4'h0;
            // An undriven clock lane idles high. Resetting to that level
            // keeps the first sample after reset from looking like an edge.
            rx_clk_s1 <= 1'b1;
            rx_clk_s2 <= 1'b1;
            rx_clk_d <= 1'b1;
            rx_pd_s1 <= 1'b0;
            rx_pd_s2 <= 1'b0;
        end else begin
            tx_word_s1 <= parallel_tx_word;
            tx_word_s2 <= tx_word_s1;
            tx_strobe_s1 <= tx_word_strobe_in;
            tx_strobe_s2 <= tx_strobe_s1;
            tx_strobe_d <= tx_strobe_s2;
            tx_pd_s1 <= tx_power_down_n;
            tx_pd_s2 <= tx_pd_s1;
            rx_lane_s1 <= serial_lane_in;
            rx_lane_s2 <= rx_lane_s1;
            rx_clk_s1 <= forwarded_clock_in;
            rx_clk_s2 <= rx_clk_s1;
            rx_clk_d <= rx_clk_s2;
            rx_pd_s1 <= rx_power_down_n;
            rx_pd_s2 <= rx_pd_s1;
        end
    end

    wire tx_edge = tx_strobe_s2 & ~tx_strobe_d;
    wire rx_edge = rx_clk_s2 & ~rx_clk_d;

    serial_link_pkg::tx_state_t tx, next_tx;
    serial_link_pkg::rx_state_t rx, next_rx;

    // Transmit side.
    always_comb begin
        next_tx = tx;
        if (tx_edge) begin
            next_tx.idle_cnt = 7'h00;
        end else if (tx.idle_cnt != serial_link_pkg::CLOCK_LOSS_CYCLES) begin
            next_tx.idle_cnt = tx.idle_cnt + 7'h01;
        end
        if (!tx_pd_s2) begin
            next_tx.mode = serial_link_pkg::TX_OFF; // R3
            next_tx.lock_cnt = 32'h0;
            next_tx.active = 1'b0;
        end else begin
            unique case (tx.mode)
                serial_link_pkg::TX_OFF: begin
                    next_tx.mode = serial_link_pkg::TX_LOCKING;
                    next_tx.lock_cnt = 32'h0;
                end
                serial_link_pkg::TX_LOCKING: begin
                    // Lock only accrues while the word clock is running.
                    if (tx.idle_cnt ==
                            serial_link_pkg::CLOCK_LOSS_CYCLES) begin
                        next_tx.lock_cnt = 32'h0;
                    end else if (tx.lock_cnt >= 32'(LOCK_CYCLES - 1)) begin
                        next_tx.mode = serial_link_pkg::TX_RUN; // R11
                    end else begin
                        next_tx.lock_cnt = tx.lock_cnt + 32'h1;
                    end
                end
                serial_link_pkg::TX_RUN: begin
                    // A stopped clock is the controller's job to handle.
                    // The lanes then go quiet, as no edge starts a frame.
                    if (tx_edge) begin
                        next_tx.word = tx_word_s2; // R1
                        next_tx.slot = 3'h0;
                        next_tx.active = 1'b1;
                    end else if (tx.active) begin
                        if (tx.slot == serial_link_pkg::LAST_SLOT) begin
                            next_tx.active = 1'b0;
                        end else begin
                            next_tx.slot = tx.slot + 3'h1; // R9
                        end
                    end
                end
            endcase
        end
        next_tx.oe = next_tx.mode == serial_link_pkg::TX_RUN; // R3 R11
        next_tx.clk_out = next_tx.oe && next_tx.active &&
            next_tx.slot < serial_link_pkg::FWD_CLK_HIGH_SLOTS; // R2
        for (int l = 0; l < L; l++) begin
            next_tx.lane_out[l] = next_tx.oe && next_tx.active &&
                next_tx.word[serial_link_pkg::bit_index(l,
                32'(next_tx.slot))]; // R12
        end
    end

    // Receive side; the frame starts on the forwarded clock rising edge.
    always_comb begin
        next_rx = rx;
        if (!rx_pd_s2) begin
            next_rx.word = serial_link_pkg::WORD_RESET; // R5
            next_rx.strobe = 1'b0; // R5
            next_rx.strobe_cnt = 3'h0;
            next_rx.locked = 1'b0;
            next_rx.frames = 3'h0;
            next_rx.busy = 1'b0;
            next_rx.idle_cnt = 7'h00;
        end else begin
            if (rx_edge) begin
                next_rx.idle_cnt = 7'h00;
            end else if (rx.idle_cnt !=
                    serial_link_pkg::CLOCK_LOSS_CYCLES) begin
                next_rx.idle_cnt = rx.idle_cnt + 7'h01;
            end else begin
                // Clock lost: relock later, but keep the last word.
                next_rx.locked = 1'b0; // R7 R13
                next_rx.frames = 3'h0;
                next_rx.busy = 1'b0;
            end
            // Several frames must arrive before a word is shown, so a relock
            // after clock loss never presents a half-sampled word.
            if (rx_edge) begin
                next_rx.slot = 3'h0;
                next_rx.busy = 1'b1;
                if (!rx.locked) begin
                    next_rx.frames = rx.frames + 3'h1;
                    next_rx.locked = next_rx.frames ==
                        serial_link_pkg::RX_LOCK_FRAMES; // R13
                end
            end else if (rx.busy) begin
                next_rx.slot = rx.slot + 3'h1;
            end
            if (rx_edge || rx.busy) begin
                for (int l = 0; l < L; l++) begin
                    next_rx.buffer[serial_link_pkg::bit_index(l,
                        32'(next_rx.slot))] = rx_lane_s2[l]; // R12 R6
                end
                if (next_rx.slot == serial_link_pkg::LAST_SLOT) begin
                    next_rx.busy = 1'b0;
                    if (rx.locked) begin
                        next_rx.word = next_rx.buffer; // R4 R13
                        next_rx.strobe = 1'b0;
                        next_rx.strobe_cnt = 3'h0;
                    end
                end
            end
            // The strobe rises after the word has settled and idles high.
            if (!rx.strobe && next_rx.strobe_cnt == rx.strobe_cnt) begin
                if (rx.strobe_cnt ==
                        serial_link_pkg::STROBE_LOW_CYCLES - 3'h1) begin
                    next_rx.strobe = 1'b1; // R4 R8
                end else begin
                    next_rx.strobe_cnt = rx.strobe_cnt + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx <= '0;
            rx <= '0;
        end else begin
            tx <= next_tx;
            rx <= next_rx;
        end
    end

    assign serial_lane_out = tx.lane_out;
    assign serial_lane_oe = {L{tx.oe}};
    assign forwarded_clock_out = tx.clk_out;
    assign forwarded_clock_oe = tx.oe;
    assign parallel_rx_word = rx.word;
    assign rx_word_strobe_out = rx.strobe;
endmodule

//--- hdl/serial_link_pkg.sv
// Constants, types and the shared bit-to-slot map for the serial link pair.
package serial_link_pkg;
    localparam int WORD_BITS = 28;
    localparam int LANES = 4;
    localparam int SLOTS = 7;
    localparam logic [2:0] LAST_SLOT = 3'h6;
    localparam logic [2:0] FWD_CLK_HIGH_SLOTS = 3'h4;
    localparam int REF_CLK_PERIOD_NS = 10;
    localparam int LOCK_TIME_MS = 10;
    localparam int LOCK_CYCLES = LOCK_TIME_MS * 1000000 / REF_CLK_PERIOD_NS;
    localparam logic [6:0] CLOCK_LOSS_CYCLES = 7'h40;
    localparam logic [2:0] RX_LOCK_FRAMES = 3'h4;
    localparam logic [2:0] STROBE_LOW_CYCLES = 3'h4;
    localparam logic [WORD_BITS-1:0] WORD_RESET = 28'h0000000;

    typedef enum logic [1:0] {TX_OFF, TX_LOCKING, TX_RUN} tx_mode_t;

    typedef struct packed {
        tx_mode_t mode;
        logic [31:0] lock_cnt;
        logic [6:0] idle_cnt;
        logic [WORD_BITS-1:0] word;
        logic [2:0] slot;
        logic active;
        logic [LANES-1:0] lane_out;
        logic clk_out;
        logic oe;
    } tx_state_t;

    typedef struct packed {
        logic [WORD_BITS-1:0] buffer;
        logic [WORD_BITS-1:0] word;
        logic [2:0] slot;
        logic busy;
        logic locked;
        logic [2:0] frames;
        logic [6:0] idle_cnt;
        logic strobe;
        logic [2:0] strobe_cnt;
    } rx_state_t;

    // Lane l carries word bits l*7 .. l*7+6, slot 0 first on the wire.
    function automatic logic [4:0] bit_index(input int lane, input int slot);
        bit_index = 5'(lane * SLOTS + slot);
    endfunction
endpackage

//--- tb/serial_link_props.sv
// Concurrent checks on the ports of the serial link pair.
`timescale 1ns/100ps
module serial_link_props #(
    parameter int LOCK_CYCLES = serial_link_pkg::LOCK_CYCLES
) (
    input wire logic ref_clk, // Clock.
    input wire logic rst_b, // Reset.
    input wire logic [27:0] parallel_tx_word, // Tx word.
    input wire logic tx_word_strobe_in, // Tx strobe.
    input wire logic tx_power_down_n, // Tx off.
    input wire logic [3:0] serial_lane_out, // Lanes.
    input wire logic [3:0] serial_lane_oe, // Lane enables.
    input wire logic forwarded_clock_out, // Clock lane.
    input wire logic forwarded_clock_oe, // Clock enable.
    input wire logic [3:0] serial_lane_in, // Rx lanes.
    input wire logic forwarded_clock_in, // Rx clock.
    input wire logic rx_power_down_n, // Rx off.
    input wire logic [27:0] parallel_rx_word, // Rx word.
    input wire logic rx_word_strobe_out // Rx strobe.
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // Power-up time; pin sync delays only make it longer than the lock count.
    logic [31:0] up_cnt;
    logic [31:0] next_up_cnt;
    always_comb begin
        next_up_cnt = tx_power_down_n ? up_cnt + 32'h1 : 32'h0;
    end
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            up_cnt <= 32'h0;
        end else begin
            up_cnt <= next_up_cnt;
        end
    end
    sequence clk_frame;
        forwarded_clock_out[*4] ##1 !forwarded_clock_out[*3];
    endsequence
    sequence strobe_pulse;
        !rx_word_strobe_out[*4] ##1 rx_word_strobe_out;
    endsequence
    oe_match_a: assert property (
        serial_lane_oe == {4{forwarded_clock_oe}})
        else $error("lane and clock enables differ");
    frame_drive_a: assert property ($rose(forwarded_clock_out) |->
        forwarded_clock_oe && serial_lane_oe == 4'hf)
        else $error("frame sent while undriven");
    clk_frame_a: assert property (
        disable iff (!rst_b || !tx_power_down_n)
        $rose(forwarded_clock_out) |-> clk_frame)
        else $error("forwarded clock frame shape wrong");
    pd_float_a: assert property (!tx_power_down_n[*3] |=>
        serial_lane_oe == 4'h0 && !forwarded_clock_oe)
        else $error("outputs driven in power-down");
    idle_zero_a: assert property (!forwarded_clock_oe |->
        serial_lane_out == 4'h0)
        else $error("lanes not zero while undriven");
    lock_wait_a: assert property ($rose(forwarded_clock_oe) |->
        up_cnt >= 32'(LOCK_CYCLES))
        else $error("drive enabled before lock time");
    rx_off_a: assert property (!rx_power_down_n[*3] |=>
        parallel_rx_word == 28'h0 && !rx_word_strobe_out)
        else $error("receiver outputs not low in power-down");
    strobe_low_a: assert property (
        disable iff (!rst_b || !rx_power_down_n)
        $fell(rx_word_strobe_out) |-> strobe_pulse)
        else $error("word strobe pulse wrong");
    word_hold_a: assert property (
        disable iff (!rst_b || !rx_power_down_n)
        !$fell(rx_word_strobe_out) |-> $stable(parallel_rx_word))
        else $error("word changed without strobe");
endmodule
bind serial_link_pair serial_link_props #(.LOCK_CYCLES(LOCK_CYCLES))
    i_serial_link_props (
    .ref_clk(ref_clk), .rst_b(rst_b), .parallel_tx_word(parallel_tx_word),
    .tx_word_strobe_in(tx_word_strobe_in), .tx_power_down_n(tx_power_down_n),
    .serial_lane_out(serial_lane_out), .serial_lane_oe(serial_lane_oe),
    .forwarded_clock_out(forwarded_clock_out),
    .forwarded_clock_oe(forwarded_clock_oe), .serial_lane_in(serial_lane_in),
    .forwarded_clock_in(forwarded_clock_in), .rx_power_down_n(rx_power_down_n),
    .parallel_rx_word(parallel_rx_word), .rx_word_strobe_out(rx_word_strobe_out));

//--- tb/link_cable.sv
// Cable model looping the serial outputs back to the serial inputs.
`timescale 1ns/100ps
module link_cable (
    input wire logic [3:0] lane_out, // Sent lanes.
    input wire logic [3:0] lane_oe, // Lane enables.
    input wire logic clk_out, // Sent clock.
    input wire logic clk_oe, // Clock enable.
    input wire logic float_lanes, // Cut data pairs.
    output logic [3:0] lane_in, // Received lanes.
    output logic clk_in // Received clock.
);
    // Undriven pairs sit at the bias level, never at their last bit.
    assign lane_in = float_lanes ? 4'hf : (lane_out | ~lane_oe);
    assign clk_in = clk_oe ? clk_out : 1'b1;
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the serial link pair.
`timescale 1ns/100ps
module tb_top;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic word_clk = 1'b0;
    logic run_clk = 1'b1;
    logic tx_pd_n = 1'b1;
    logic rx_pd_n = 1'b1;
    logic float_lanes = 1'b0;
    logic watch = 1'b0;
    logic prev = 1'b0;
    logic [27:0] tx_word = 28'h0;
    logic [27:0] rx_word;
    logic [3:0] lane_out, lane_oe, lane_in;
    logic fclk_out, fclk_oe, fclk_in, strobe;
    logic [27:0] expq[$];
    int failures = 0;
    int checks = 0;
    int cycles = 0;
    initial forever #5 ref_clk = ~ref_clk;
    initial begin
        #3;
        forever #40 word_clk = run_clk & ~word_clk;
    end
    serial_link_pair #(.LOCK_CYCLES(20)) i_serial_link_pair (
        .ref_clk(ref_clk), .rst_b(rst_b), .parallel_tx_word(tx_word),
        .tx_word_strobe_in(word_clk), .tx_power_down_n(tx_pd_n),
        .serial_lane_out(lane_out), .serial_lane_oe(lane_oe),
        .forwarded_clock_out(fclk_out), .forwarded_clock_oe(fclk_oe),
        .serial_lane_in(lane_in), .forwarded_clock_in(fclk_in),
        .rx_power_down_n(rx_pd_n), .parallel_rx_word(rx_word),
        .rx_word_strobe_out(strobe));
    link_cable i_link_cable (.lane_out(lane_out), .lane_oe(lane_oe),
        .clk_out(fclk_out), .clk_oe(fclk_oe), .float_lanes(float_lanes),
        .lane_in(lane_in), .clk_in(fclk_in));
    task automatic end_sim();
        $display("Checks %0d, failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [27:0] got, input logic [27:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic send(input logic [27:0] w);
        @(negedge word_clk);
        @(negedge ref_clk);
        tx_word = w;
        expq.push_back(w);
    endtask
    always @(negedge ref_clk) begin
        cycles++;
        if (cycles > 5000) begin
            failures++;
            end_sim();
        end
        if (watch && prev && !strobe && expq.size() > 0)
            check(rx_word, expq.pop_front());
        prev = strobe;
    end
    initial begin
        void'($urandom(32'h11fb));
        repeat (20) @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (30) @(negedge word_clk);
        send(28'hfffffff);
        // A frame of the initial 28'h0000000 word is still in flight; let it pass.
        @(negedge strobe);
        repeat (2) @(negedge ref_clk);
        watch = 1'b1;
        // The next word clock rise is close; load its word here so that
        // no rise carries the warm-up word a second time.
        tx_word = 28'h0000000;
        expq.push_back(28'h0000000);
        repeat (14) send(28'($urandom()));
        repeat (30) @(negedge ref_clk);
        check(28'(expq.size()), 28'h0);
        watch = 1'b0;
        float_lanes = 1'b1;
        repeat (8) @(negedge word_clk);
        check(rx_word, 28'hfffffff);
        @(negedge ref_clk);
        tx_pd_n = 1'b0;
        repeat (6) @(negedge ref_clk);
        check(28'({lane_oe, fclk_oe}), 28'h0);
        run_clk = 1'b0;
        tx_word = 28'h5a3c0f1;
        repeat (100) @(negedge ref_clk);
        check(rx_word, 28'hfffffff);
        check(28'(strobe), 28'h1);
        run_clk = 1'b1;
        repeat (4) @(negedge word_clk);
        @(negedge ref_clk);
        tx_pd_n = 1'b1;
        float_lanes = 1'b0;
        repeat (30) @(negedge word_clk);
        check(28'(fclk_oe), 28'h1);
        check(rx_word, 28'h5a3c0f1);
        @(negedge ref_clk);
        rx_pd_n = 1'b0;
        repeat (6) @(negedge ref_clk);
        check(rx_word, 28'h0);
        check(28'(strobe), 28'h0);
        end_sim();
    end
endmodule
